// file: design/pin_wake_regs.vh
`ifndef PIN_WAKE_REGS_VH
`define PIN_WAKE_REGS_VH
// register addresses on the special-function bus
`define ADDR_POWER_MODE 8'h87
`define ADDR_TIMER_EXT_CTRL 8'h88
`define ADDR_EXTRA_FLAGS 8'h95
`define ADDR_P1_WAKE_MASK 8'h96
`define ADDR_IRQ_ENABLE 8'hA8
`define ADDR_IRQ_ENABLE_1 8'hA9
// power mode control fields
`define PM_IDLE_BIT 0
`define PM_PDOWN_BIT 1
// timer and external irq control fields
`define TC_A_TYPE_BIT 0
`define TC_A_FLAG_BIT 1
`define TC_B_TYPE_BIT 2
`define TC_B_FLAG_BIT 3
// extra flag fields
`define XF_P1_FLAG_BIT 1
`define XF_C_FLAG_BIT 2
// enable register fields
`define IE_A_BIT 0
`define IE_B_BIT 2
`define IE_GLOBAL_BIT 7
`define IE1_P1_BIT 1
`define IE1_C_BIT 2
// reset values
`define RST_BYTE 8'h00
`define RST_PINS 1'b1
// vector addresses
`define VEC_PIN_A 16'h0003
`define VEC_PIN_B 16'h0013
`define VEC_P1 16'h0043
`define VEC_PIN_C 16'h004B
`define VEC_NONE 16'h0000
// oscillator warm-up after stop, in cycles
`define WARMUP_CYCLES 16'h0010
`define WARMUP_ONE 16'h0001
`define WARMUP_ZERO 16'h0000
`endif

// file: design/pin_interrupt_wakeup.v
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "pin_wake_regs.vh"

// Contract
// - pin a, b, c map to P3.2/P3.3/P3.7
// - pins a/b: type 0 level, 1 falling
// - pin c falling edge only
// - any masked Port1 pin change triggers
// - a/b edge sets flag regardless enable
// - c edge sets flag regardless enable
// - vectoring clears the pin flag
// - port one flag needs per-pin mask
// - flag write zero clears, one keeps; a write to the a/b flags in the timer control takes the written value
// - power-down bit stops, idle bit idles
// - idle wake needs enable and global
// - idle wake enters service at once
// - enables arm stop wake per pin
// - stop wake resumes before servicing
// - stop wake interrupts only when enabled
// - pins sampled after warm-up, port async
// - refuse stop while armed pin low
// - stop wake ignores global enable
// - vectors 0003, 0013, 0043, 004B
module pin_interrupt_wakeup #(
	parameter WARMUP = `WARMUP_CYCLES
) (
	// clock and reset
	input wire sys_clk,
	input wire reset,
	// register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// port pins
	input wire [7:0] port3_pins,
	input wire [7:0] port1_pins,
	// cpu interrupt interface
	output wire irq_request,
	output reg [15:0] irq_vector,
	input wire irq_ack,
	input wire [15:0] ack_vector,
	input wire irq_return,
	// power state
	output wire core_idle,
	output wire core_stopped,
	output wire osc_warming
);

	// power states
	localparam ST_RUN = 4'b0001;
	localparam ST_IDLE = 4'b0010;
	localparam ST_STOP = 4'b0100;
	localparam ST_WARM = 4'b1000;

	// wake sequence in brief:
	// run -> idle on the idle bit, back to run once any enabled request stands;
	// run -> stop on the power-down bit unless an armed pin already sits low;
	// stop -> warm on an armed low pin or a masked port one change, with the
	// global enable ignored, since no clock runs the cpu while stopped anyway;
	// warm -> run after the warm-up count, and the request stays gated until the
	// first register access, which stands for the instruction after the stop.
	// limitation: a pin pulse shorter than the warm-up wakes the
	// core from stop but leaves no flag, so the core resumes without a service.
	// port one changes are compared cycle by cycle against the last level,
	// so a glitch shorter than one clock is missed while the clock runs.
	// trade-off: the stop refusal looks at the raw pins, so a pin that has
	// just gone low blocks stop even before the synchroniser has seen it.

	reg [7:0] pm_r;
	reg [7:0] tc_r;
	reg [7:0] xf_r;
	reg [7:0] wake_mask_r;
	reg [7:0] ie_r;
	reg [7:0] ie1_r;
	reg [3:0] state_r;
	reg [3:0] state_nxt;
	reg [15:0] warm_r;
	reg [2:0] pin_s1_r;
	reg [2:0] pin_s2_r;
	reg [2:0] pin_prev_r;
	reg [7:0] p1_prev_r;
	reg p1_stop_wake_r;
	reg stop_resume_r;

	wire [2:0] pins_raw;
	wire [2:0] pin_fall;
	wire [7:0] p1_change;
	wire p1_event;
	wire sampling;
	wire pend_a;
	wire pend_b;
	wire req_a;
	wire req_b;
	wire req_c;
	wire req_p1;
	wire any_req;
	wire stop_arm_low;
	wire stop_wake;
	wire leave_warm;
	// decoded register writes
	wire wr_pm;
	wire wr_tc;
	wire wr_xf;
	wire wr_mask;
	wire wr_ie;
	wire wr_ie1;
	// decoded vector acknowledges, one per flag that vectoring clears
	wire ack_a;
	wire ack_b;
	wire ack_c;
	wire ack_p1;
	// qualified falling edges, one per external pin
	wire fall_a;
	wire fall_b;
	wire fall_c;

	function is_wr;
		input [7:0] a;
		begin
			is_wr = reg_wr && (reg_addr == a);
		end
	endfunction

	// one decode per register, shared by every process that writes it; the power state logic decodes the power mode write again
	assign wr_pm = is_wr(`ADDR_POWER_MODE);
	assign wr_tc = is_wr(`ADDR_TIMER_EXT_CTRL);
	assign wr_xf = is_wr(`ADDR_EXTRA_FLAGS);
	assign wr_mask = is_wr(`ADDR_P1_WAKE_MASK);
	assign wr_ie = is_wr(`ADDR_IRQ_ENABLE);
	assign wr_ie1 = is_wr(`ADDR_IRQ_ENABLE_1);

	// an acknowledge clears only the flag whose vector the cpu took
	assign ack_a = irq_ack && (ack_vector == `VEC_PIN_A);
	assign ack_b = irq_ack && (ack_vector == `VEC_PIN_B);
	assign ack_c = irq_ack && (ack_vector == `VEC_PIN_C);
	assign ack_p1 = irq_ack && (ack_vector == `VEC_P1);

	// pins a, b, c on port3 bits 2, 3, 7
	assign pins_raw = {port3_pins[7], port3_pins[3], port3_pins[2]};

	// pins frozen during stop and warm-up: the clock is not there to sample
	assign sampling = (state_r == ST_RUN) || (state_r == ST_IDLE);
	assign pin_fall = pin_prev_r & ~pin_s2_r & {3{sampling}};

	// a/b edges only count in edge mode; in level mode the pin itself requests
	assign fall_a = pin_fall[0] && tc_r[`TC_A_TYPE_BIT];
	assign fall_b = pin_fall[1] && tc_r[`TC_B_TYPE_BIT];
	assign fall_c = pin_fall[2];

	// port one change seen on any pin whose mask bit is set
	assign p1_change = (port1_pins ^ p1_prev_r) & wake_mask_r;
	assign p1_event = |p1_change;

	// level mode: the pending state follows the low pin while type is 0
	assign pend_a = tc_r[`TC_A_TYPE_BIT] ? tc_r[`TC_A_FLAG_BIT] : ~pin_s2_r[0];
	assign pend_b = tc_r[`TC_B_TYPE_BIT] ? tc_r[`TC_B_FLAG_BIT] : ~pin_s2_r[1];

	// requests need individual and global enable
	assign req_a = pend_a && ie_r[`IE_A_BIT] && ie_r[`IE_GLOBAL_BIT];
	assign req_b = pend_b && ie_r[`IE_B_BIT] && ie_r[`IE_GLOBAL_BIT];
	assign req_c = xf_r[`XF_C_FLAG_BIT] && ie1_r[`IE1_C_BIT] && ie_r[`IE_GLOBAL_BIT];
	assign req_p1 = xf_r[`XF_P1_FLAG_BIT] && ie1_r[`IE1_P1_BIT] && ie_r[`IE_GLOBAL_BIT];
	assign any_req = req_a | req_b | req_c | req_p1;

	// held off for one instruction after stop wake; idle wake goes straight in
	assign irq_request = any_req && sampling && !stop_resume_r;

	// armed pin sitting low blocks stop entry
	assign stop_arm_low = (~pins_raw[0] & ie_r[`IE_A_BIT]) |
		(~pins_raw[1] & ie_r[`IE_B_BIT]) |
		(~pins_raw[2] & ie1_r[`IE1_C_BIT]);

	// stop wake from an armed pin low level or port one change, global enable ignored
	assign stop_wake = stop_arm_low | p1_event;

	assign core_idle = (state_r == ST_IDLE);
	assign core_stopped = (state_r == ST_STOP);
	assign osc_warming = (state_r == ST_WARM);
	// last warm-up cycle, where the resume gate closes
	assign leave_warm = (state_r == ST_WARM) && (state_nxt == ST_RUN);

	// vector priority follows the cpu's natural order
	always @* begin
		if (req_a)
			irq_vector = `VEC_PIN_A;
		else if (req_b)
			irq_vector = `VEC_PIN_B;
		else if (req_p1)
			irq_vector = `VEC_P1;
		else if (req_c)
			irq_vector = `VEC_PIN_C;
		else
			irq_vector = `VEC_NONE;
	end

	// power state sequencing
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_RUN: begin
				if (is_wr(`ADDR_POWER_MODE) && reg_wdata[`PM_PDOWN_BIT] && !stop_arm_low)
					state_nxt = ST_STOP;
				else if (is_wr(`ADDR_POWER_MODE) && reg_wdata[`PM_IDLE_BIT])
					state_nxt = ST_IDLE;
			end
			ST_IDLE: begin
				if (any_req)
					state_nxt = ST_RUN;
			end
			ST_STOP: begin
				if (stop_wake)
					state_nxt = ST_WARM;
			end
			ST_WARM: begin
				if (warm_r == `WARMUP_ONE)
					state_nxt = ST_RUN;
			end
			default: state_nxt = ST_RUN;
		endcase
	end

	// power state register
	always @(posedge sys_clk) begin
		if (reset) begin
			state_r <= ST_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	// warm-up counter: loaded while stopped, counts down as the oscillator settles
	always @(posedge sys_clk) begin
		if (reset) begin
			warm_r <= `WARMUP_ZERO;
		end else if (state_r == ST_STOP) begin
			warm_r <= WARMUP[15:0];
		end else if (warm_r != `WARMUP_ZERO) begin
			warm_r <= warm_r - `WARMUP_ONE;
		end
	end

	// resume gate: the next register access stands for the first instruction after stop
	always @(posedge sys_clk) begin
		if (reset) begin
			stop_resume_r <= 1'b0;
		end else if (leave_warm) begin
			stop_resume_r <= 1'b1;
		end else if (reg_wr || reg_rd) begin
			stop_resume_r <= 1'b0;
		end
	end

	// two-flop synchroniser; only the second stage feeds logic
	always @(posedge sys_clk) begin
		if (reset) begin
			pin_s1_r <= {3{`RST_PINS}};
			pin_s2_r <= {3{`RST_PINS}};
			pin_prev_r <= {3{`RST_PINS}};
		end else begin
			pin_s1_r <= pins_raw;
			pin_s2_r <= pin_s1_r;
			if (sampling)
				pin_prev_r <= pin_s2_r;
		end
	end

	// port one history; a stop-time change is remembered so its flag is not lost
	always @(posedge sys_clk) begin
		if (reset) begin
			p1_prev_r <= {8{`RST_PINS}};
			p1_stop_wake_r <= 1'b0;
		end else begin
			p1_prev_r <= port1_pins;
			p1_stop_wake_r <= p1_event && (state_r == ST_STOP);
		end
	end

	// power mode register; the power-down bit mirrors stop and warm-up, the idle bit is set in idle, cleared in run and otherwise holds its value
	always @(posedge sys_clk) begin
		if (reset) begin
			pm_r <= `RST_BYTE;
		end else begin
			if (wr_pm)
				pm_r <= reg_wdata;
			if (state_nxt == ST_RUN)
				pm_r[`PM_IDLE_BIT] <= 1'b0;
			else if (state_nxt == ST_IDLE)
				pm_r[`PM_IDLE_BIT] <= 1'b1;
			pm_r[`PM_PDOWN_BIT] <= (state_nxt == ST_STOP) || (state_nxt == ST_WARM);
		end
	end

	// enable and wake mask registers, plain read-write
	always @(posedge sys_clk) begin
		if (reset) begin
			wake_mask_r <= `RST_BYTE;
			ie_r <= `RST_BYTE;
			ie1_r <= `RST_BYTE;
		end else begin
			if (wr_mask)
				wake_mask_r <= reg_wdata;
			if (wr_ie)
				ie_r <= reg_wdata;
			if (wr_ie1)
				ie1_r <= reg_wdata;
		end
	end

	// timer and pin control; a flag set wins over a clear in the same cycle
	always @(posedge sys_clk) begin
		if (reset) begin
			tc_r <= `RST_BYTE;
		end else begin
			if (wr_tc)
				tc_r <= reg_wdata;
			if (ack_a)
				tc_r[`TC_A_FLAG_BIT] <= 1'b0;
			if (ack_b)
				tc_r[`TC_B_FLAG_BIT] <= 1'b0;
			if (fall_a)
				tc_r[`TC_A_FLAG_BIT] <= 1'b1;
			if (fall_b)
				tc_r[`TC_B_FLAG_BIT] <= 1'b1;
		end
	end

	// extra flags: zero clears, one leaves the bit alone, a hardware set wins
	always @(posedge sys_clk) begin
		if (reset) begin
			xf_r <= `RST_BYTE;
		end else begin
			if (wr_xf)
				xf_r <= xf_r & reg_wdata;
			if (ack_c)
				xf_r[`XF_C_FLAG_BIT] <= 1'b0;
			if (ack_p1)
				xf_r[`XF_P1_FLAG_BIT] <= 1'b0;
			if (fall_c)
				xf_r[`XF_C_FLAG_BIT] <= 1'b1;
			if (p1_event || p1_stop_wake_r)
				xf_r[`XF_P1_FLAG_BIT] <= 1'b1;
		end
	end

	// read data one cycle after the strobe; unmapped reads as zero
	always @(posedge sys_clk) begin
		if (reset) begin
			reg_rdata <= `RST_BYTE;
		end else if (reg_rd) begin
			case (reg_addr)
				`ADDR_POWER_MODE: reg_rdata <= pm_r;
				`ADDR_TIMER_EXT_CTRL: reg_rdata <= tc_r;
				`ADDR_EXTRA_FLAGS: reg_rdata <= xf_r;
				`ADDR_P1_WAKE_MASK: reg_rdata <= wake_mask_r;
				`ADDR_IRQ_ENABLE: reg_rdata <= ie_r;
				`ADDR_IRQ_ENABLE_1: reg_rdata <= ie1_r;
				default: reg_rdata <= `RST_BYTE;
			endcase
		end else begin
			reg_rdata <= `RST_BYTE;
		end
	end

	// irq_return needs no state here: the idle bit is already clear
	wire unused_ok;
	assign unused_ok = irq_return;

endmodule // pin_interrupt_wakeup

// file: verif/pin_wake_chk.sv
`timescale 1ns/1ps
module pin_wake_chk #(
	parameter int WARMUP = 16
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// register read port
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// core side
	input wire logic irq_request,
	input wire logic [15:0] irq_vector,
	input wire logic core_idle,
	input wire logic core_stopped,
	input wire logic osc_warming
);
	localparam int WMAX = WARMUP + 2;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// warm-up has a bounded length, so a stuck oscillator flag shows
	sequence warm_up; osc_warming ##[1:WMAX] !osc_warming; endsequence
	AST_VECTOR: assert property (irq_request |-> irq_vector[15:8] == 8'h00 &&
		irq_vector[7:0] inside {8'h03, 8'h13, 8'h43, 8'h4B}) else $error("bad vector");
	AST_ASLEEP: assert property (core_stopped || osc_warming |-> !irq_request)
		else $error("request while asleep");
	AST_WAKE: assert property ($fell(core_stopped) |-> warm_up)
		else $error("no warm-up");
	AST_HOLD: assert property ($fell(osc_warming) |-> !irq_request)
		else $error("request before resume");
	AST_IDLE_WAKE: assert property (core_idle && irq_request |=> !core_idle)
		else $error("idle kept");
	AST_IDLE_VEC: assert property ($fell(core_idle) |-> $past(irq_request))
		else $error("idle left without request");
	AST_ONE_MODE: assert property (!(core_idle && (core_stopped || osc_warming)))
		else $error("two modes");
	AST_RD_SLOT: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside slot");
endmodule // pin_wake_chk
bind pin_interrupt_wakeup pin_wake_chk #(.WARMUP(WARMUP)) chk (.sys_clk(sys_clk),
	.reset(reset), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_request(irq_request),
	.irq_vector(irq_vector), .core_idle(core_idle), .core_stopped(core_stopped),
	.osc_warming(osc_warming));

// file: verif/pin_source.sv
`timescale 1ns/1ps
module pin_source (
	// bench control
	input wire logic [2:0] low_req,
	input wire logic [7:0] p1_level,
	// pins
	output logic [7:0] port3_pins,
	output logic [7:0] port1_pins
);
	// pins a, b, c at bits 2, 3, 7; released lines return high on the pull-ups
	assign port3_pins = {~low_req[2], 3'h7, ~low_req[1], ~low_req[0], 2'h3};
	assign port1_pins = p1_level;
endmodule // pin_source

// file: verif/tb.sv
`timescale 1ns/1ps
module tb;
	logic sys_clk = 1'h0, reset = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, irq_ack = 1'h0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, p1_level = 8'h01, reg_rdata, p3, p1;
	logic [2:0] low_req = 3'h0;
	logic [15:0] ack_vector = 16'h0000, irq_vector;
	logic irq_request, core_idle, core_stopped, osc_warming;
	int mismatches = 0, checked = 0, cyc = 0;
	initial forever #5 sys_clk = ~sys_clk;
	pin_source src (.low_req(low_req), .p1_level(p1_level), .port3_pins(p3), .port1_pins(p1));
	pin_interrupt_wakeup #(.WARMUP(2)) dut (.sys_clk(sys_clk), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .port3_pins(p3), .port1_pins(p1), .irq_request(irq_request),
		.irq_vector(irq_vector), .irq_ack(irq_ack), .ack_vector(ack_vector),
		.irq_return(1'h0), .core_idle(core_idle), .core_stopped(core_stopped),
		.osc_warming(osc_warming));
	task automatic ck(input logic [15:0] s, input logic [15:0] e, input string n);
		checked++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask
	// waits end at a falling edge, so outputs have settled
	task automatic wt(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'h1};
		@(posedge sys_clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		{reg_addr, reg_rd} <= {a, 1'h1};
		@(posedge sys_clk);
		reg_rd <= 1'h0;
		wt(1);
		ck({8'h00, reg_rdata}, {8'h00, e}, "reg_rdata");
	endtask
	// low pulse long enough to pass the synchroniser
	task automatic pin(input int b);
		@(posedge sys_clk);
		low_req[b] <= 1'h1;
		repeat (4) @(posedge sys_clk);
		low_req[b] <= 1'h0;
		repeat (4) @(posedge sys_clk);
		wt(1);
	endtask
	// pin levels change right after a rising edge
	task automatic drv(input logic [2:0] l, input logic [7:0] p);
		@(posedge sys_clk);
		{low_req, p1_level} <= {l, p};
	endtask
	task automatic ack(input logic [15:0] v);
		@(posedge sys_clk);
		{irq_ack, ack_vector} <= {1'h1, v};
		@(posedge sys_clk);
		irq_ack <= 1'h0;
	endtask
	task automatic report_and_stop;
		if (mismatches == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// hang guard
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			report_and_stop;
		end
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		reset <= 1'h0;
		rd(8'h88, 8'h00);
		rd(8'h90, 8'h00);
		// edge flags b and c set with every enable off, the c flag cleared by writing zero
		wr(8'h88, 8'h04);
		pin(1);
		rd(8'h88, 8'h0C);
		pin(2);
		rd(8'h95, 8'h04);
		wr(8'h95, 8'hFD);
		rd(8'h95, 8'h04);
		wr(8'h95, 8'hFB);
		rd(8'h95, 8'h00);
		// only masked port one pins raise the change flag
		wr(8'h96, 8'h01);
		drv(3'h0, 8'h03);
		rd(8'h95, 8'h00);
		drv(3'h0, 8'h02);
		rd(8'h95, 8'h02);
		wr(8'h95, 8'hFD);
		// level mode on pin a follows the pin
		wr(8'h88, 8'h00);
		wr(8'hA8, 8'h81);
		drv(3'h1, 8'h02);
		wt(4);
		ck(irq_vector, 16'h0003, "irq_vector");
		drv(3'h0, 8'h02);
		wt(4);
		ck(16'(irq_request), 16'h0000, "irq_request");
		// vectoring clears the pin b flag
		wr(8'h88, 8'h04);
		wr(8'hA8, 8'h84);
		pin(1);
		ck(irq_vector, 16'h0013, "irq_vector");
		ack(16'h0013);
		rd(8'h88, 8'h04);
		// idle wake needs the global enable too
		wr(8'hA8, 8'h04);
		wr(8'h87, 8'h01);
		pin(1);
		ck(16'(core_idle), 16'h0001, "core_idle");
		wr(8'hA8, 8'h84);
		wt(2);
		ck(16'(core_idle), 16'h0000, "core_idle");
		ck(irq_vector, 16'h0013, "irq_vector");
		ack(16'h0013);
		// stop refused while an armed pin is low
		wr(8'hA8, 8'h01);
		drv(3'h1, 8'h02);
		wt(4);
		wr(8'h87, 8'h02);
		wt(1);
		ck(16'(core_stopped), 16'h0000, "core_stopped");
		drv(3'h0, 8'h02);
		// port one wake, then request held until the first access
		wr(8'hA8, 8'h80);
		wr(8'hA9, 8'h02);
		wr(8'h87, 8'h02);
		wt(1);
		ck(16'(core_stopped), 16'h0001, "core_stopped");
		drv(3'h0, 8'h03);
		wt(2);
		ck(16'(osc_warming), 16'h0001, "osc_warming");
		for (int i = 0; i < 40 && (core_stopped || osc_warming); i++) wt(1);
		ck(16'(irq_request), 16'h0000, "irq_request");
		rd(8'h95, 8'h02);
		ck(irq_vector, 16'h0043, "irq_vector");
		ack(16'h0043);
		rd(8'h95, 8'h00);
		report_and_stop;
	end
endmodule // tb
